// ---- rtl/crypto_guard_pkg.sv ----
// Purpose: Constants and types of the crypto supervisory guard
// Assumes: One 20 MHz clock, plain register port with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
//
// How it works
// - Failed self-test: error code, register reads still answered, all else refused
// - Self-tests launch by themselves after reset
// - Failed self-test: no traffic, requests returned unacted
// - Five known-answer tests run in sequence
// - No service until every test passed
// - Every reset reruns the whole test sequence
// - Crypto or bypass chosen from metadata bits and the control register protocol enables
// - Metadata of every packet checked, both paths
// - Receive: invalid bits bypass, crypto status 0
// - Transmit: drop 0 on success, 1 on error; result lost if a new packet arrives in the same cycle
// - Transmit bypass packets get drop flag 0
// - ECC fault: fatal interrupt, hard error, outputs frozen
// - IV is 32-bit salt plus 64-bit counter
// - Store IV: store salt plus add counter
// - Stall output until new counter exceeds previous
// - Store add counter needs no wrap detection
// - ESP IV: salt plus packet sequence number
// - Sequence number wrap deactivates the association
// - PSP IV: SPI plus free-running master timer
// - PSP association lifetime capped near two days
package crypto_guard_pkg;

  // ==================== Timing
  localparam logic [63:0] CLK_PERIOD_NS = 64'h0000_0000_0000_0032;
  localparam logic [63:0] NS_PER_S      = 64'h0000_0000_3B9A_CA00;
  localparam logic [63:0] CLK_HZ        = NS_PER_S / CLK_PERIOD_NS;
  localparam logic [63:0] PSP_LIFE_S    = 64'h0000_0000_0002_A300;  // two days
  localparam logic [63:0] PSP_LIFE_CYC  = PSP_LIFE_S * CLK_HZ;

  // ==================== Register map
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_CTRL     = 8'h04;
  localparam logic [7:0]  ADDR_ADD_LO   = 8'h08;
  localparam logic [7:0]  ADDR_ADD_HI   = 8'h0C;
  localparam logic [1:0]  PROTO_EN_RST  = 2'h3;

  // ==================== Self-test
  localparam logic [2:0]  KAT_LAST      = 3'h4;
  localparam logic [3:0]  ERR_NONE      = 4'h0;
  localparam logic [3:0]  ERR_ECC       = 4'hF;

  // ==================== Metadata control field
  localparam int          META_W        = 4;
  localparam logic [1:0]  PROTO_ESP     = 2'h1;
  localparam logic [1:0]  PROTO_PSP     = 2'h2;

  // ==================== IV sources
  localparam logic [1:0]  IV_STORE      = 2'h0;
  localparam logic [1:0]  IV_ESP        = 2'h1;
  localparam logic [1:0]  IV_PSP        = 2'h2;

  typedef enum logic [2:0] {
    ST_KAT_START,
    ST_KAT_WAIT,
    ST_READY,
    ST_TEST_ERR,
    ST_HARD_ERR
  } guard_state_t;

endpackage

// ---- rtl/crypto_selftest_bypass_iv_guard.sv ----
// Purpose: Self-test sequencing, bypass decisions and IV guard
// Assumes: Known-answer engines, datapaths and memories share mclk_i
// Notes:   All state but the reset release flops lives in one struct, registered once
`timescale 1ns/1ps
module crypto_selftest_bypass_iv_guard
  import crypto_guard_pkg::*;
#(
  parameter logic [63:0] PSP_LIFE = PSP_LIFE_CYC,
  parameter int          ECC_N    = 4
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // Known-answer test engines
  output logic                   kat_start_o,
  output logic      [2:0]        kat_id_o,
  input  wire logic              kat_done_i,
  input  wire logic              kat_pass_i,
  // Status
  output logic                   svc_ready_o,
  output logic                   test_err_o,
  output logic      [3:0]        err_code_o,
  output logic                   hard_err_o,
  output logic                   fatal_irq_o,
  input  wire logic [ECC_N-1:0]  ecc_err_i,
  // Receive path
  input  wire logic              rx_valid_i,
  input  wire logic [META_W-1:0] rx_meta_i,
  output logic                   rx_ready_o,
  output logic                   rx_dec_valid_o,
  output logic                   rx_crypto_o,
  // Transmit path
  input  wire logic              tx_valid_i,
  input  wire logic [META_W-1:0] tx_meta_i,
  output logic                   tx_ready_o,
  output logic                   tx_dec_valid_o,
  output logic                   tx_crypto_o,
  input  wire logic              tx_proc_done_i,
  input  wire logic              tx_proc_err_i,
  output logic                   tx_drop_valid_o,
  output logic                   tx_drop_o,
  // IV builder
  input  wire logic              sa_add_i,
  input  wire logic              esp_sa_open_i,
  input  wire logic              psp_sa_open_i,
  input  wire logic              iv_req_i,
  input  wire logic [1:0]        iv_kind_i,
  input  wire logic [31:0]       iv_salt_i,
  input  wire logic [63:0]       esp_seq_i,
  output logic                   iv_ready_o,
  output logic                   iv_valid_o,
  output logic      [95:0]       iv_o,
  output logic                   sa_deact_o,
  output logic                   psp_expired_o
);

  // ==================== Types and helpers
  typedef struct packed {
    guard_state_t st;
    logic [2:0]   kat_id;
    logic         kat_go;
    logic [3:0]   err_code;
    logic [1:0]   proto_en;
    logic [31:0]  rdata;
    logic         rx_dv;
    logic         rx_crypto;
    logic         tx_dv;
    logic         tx_crypto;
    logic         drop_v;
    logic         drop;
    logic [63:0]  add_cnt;
    logic [63:0]  tmr;
    logic [63:0]  last_add;
    logic [63:0]  last_esp;
    logic         esp_seen;
    logic [63:0]  last_psp;
    logic [63:0]  psp_start;
    logic         psp_live;
    logic [95:0]  iv;
    logic         iv_v;
    logic         deact;
  } guard_regs_t;

  // Crypto only for a well-formed request aimed at this path
  function automatic logic meta_ok(input logic [META_W-1:0] m, input logic dir, input logic [1:0] en);
    meta_ok = m[0] && (m[1] == dir) &&
              (((m[3:2] == PROTO_ESP) && en[0]) || ((m[3:2] == PROTO_PSP) && en[1]));
  endfunction

  // ==================== Reset release
  logic [1:0]  rst_q;
  logic        rst_n;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==================== Next state
  guard_regs_t s_q;
  guard_regs_t s_d;
  logic        ecc_any;
  logic        svc;
  logic        psp_exp;
  logic        iv_ok;
  logic        rx_ok;
  logic        tx_ok;

  assign ecc_any = |ecc_err_i;
  assign svc     = (s_q.st == ST_READY) && !ecc_any;
  assign psp_exp = s_q.psp_live && ((s_q.tmr - s_q.psp_start) >= PSP_LIFE);
  assign rx_ok   = meta_ok(rx_meta_i, 1'b0, s_q.proto_en);
  assign tx_ok   = meta_ok(tx_meta_i, 1'b1, s_q.proto_en);

  // Counter must strictly exceed the last one; ESP wraps and bad kinds are refused, not stalled
  always_comb begin
    iv_ok = 1'b1;
    case (iv_kind_i)
      IV_STORE: iv_ok = s_q.add_cnt > s_q.last_add;
      IV_PSP:   iv_ok = psp_exp || (s_q.tmr > s_q.last_psp);
      default:  iv_ok = 1'b1;
    endcase
  end

  always_comb begin
    s_d        = s_q;
    s_d.kat_go = 1'b0;
    s_d.rx_dv  = 1'b0;
    s_d.tx_dv  = 1'b0;
    s_d.drop_v = 1'b0;
    s_d.iv_v   = 1'b0;
    s_d.deact  = 1'b0;
    s_d.tmr    = s_q.tmr + 64'h0000_0000_0000_0001;
    if (sa_add_i) begin
      s_d.add_cnt = s_q.add_cnt + 64'h0000_0000_0000_0001;
    end

    // Register port: status always readable, writes only while in service
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: s_d.rdata = {21'h00_0000, s_q.kat_id, s_q.err_code, 1'b0,
                                  s_q.st == ST_HARD_ERR, s_q.st == ST_TEST_ERR, s_q.st == ST_READY};
        ADDR_CTRL:   s_d.rdata = {30'h0000_0000, s_q.proto_en};
        ADDR_ADD_LO: s_d.rdata = s_q.add_cnt[31:0];
        ADDR_ADD_HI: s_d.rdata = s_q.add_cnt[63:32];
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr_i && svc && (reg_addr_i == ADDR_CTRL)) begin
      s_d.proto_en = reg_wdata_i[1:0];
    end

    // Self-test sequencer
    case (s_q.st)
      ST_KAT_START: begin
        s_d.kat_go = 1'b1;
        s_d.st     = ST_KAT_WAIT;
      end
      ST_KAT_WAIT: begin
        if (kat_done_i && kat_pass_i) begin
          if (s_q.kat_id == KAT_LAST) begin
            s_d.st = ST_READY;
          end else begin
            s_d.kat_id = s_q.kat_id + 3'h1;
            s_d.st     = ST_KAT_START;
          end
        end else if (kat_done_i) begin
          s_d.err_code = {1'b0, s_q.kat_id} + 4'h1;
          s_d.st       = ST_TEST_ERR;
        end
      end
      ST_READY:    s_d.st = ST_READY;
      ST_TEST_ERR: s_d.st = ST_TEST_ERR;
      ST_HARD_ERR: s_d.st = ST_HARD_ERR;
      default:     s_d.st = ST_HARD_ERR;
    endcase

    // Bypass decisions, one per packet
    if (svc && rx_valid_i) begin
      s_d.rx_dv     = 1'b1;
      s_d.rx_crypto = rx_ok;
    end
    if (svc && tx_valid_i) begin
      s_d.tx_dv     = 1'b1;
      s_d.tx_crypto = tx_ok;
      if (!tx_ok) begin
        s_d.drop_v = 1'b1;
        s_d.drop   = 1'b0;
      end
    end else if (svc && tx_proc_done_i) begin
      s_d.drop_v = 1'b1;
      s_d.drop   = tx_proc_err_i;
    end

    // IV builder
    if (esp_sa_open_i) begin
      s_d.esp_seen = 1'b0;
    end
    if (psp_sa_open_i) begin
      s_d.psp_live  = 1'b1;
      s_d.psp_start = s_q.tmr;
    end
    if (svc && iv_req_i && iv_ok) begin
      case (iv_kind_i)
        IV_STORE: begin
          s_d.iv       = {iv_salt_i, s_q.add_cnt};
          s_d.iv_v     = 1'b1;
          s_d.last_add = s_q.add_cnt;
        end
        IV_ESP: begin
          if (s_q.esp_seen && (esp_seq_i <= s_q.last_esp)) begin
            // Stays armed: a wrapped number must keep being refused
            s_d.deact    = 1'b1;
          end else begin
            s_d.iv       = {iv_salt_i, esp_seq_i};
            s_d.iv_v     = 1'b1;
            s_d.last_esp = esp_seq_i;
            s_d.esp_seen = 1'b1;
          end
        end
        IV_PSP: begin
          if (psp_exp) begin
            // Stays expired until reopened, so the key is never served again
            s_d.deact    = 1'b1;
          end else begin
            s_d.iv       = {iv_salt_i, s_q.tmr};
            s_d.iv_v     = 1'b1;
            s_d.last_psp = s_q.tmr;
          end
        end
        default: s_d.deact = 1'b1;
      endcase
    end

    // Memory fault freezes every data output; wins over all else
    if (ecc_any || (s_q.st == ST_HARD_ERR)) begin
      s_d           = s_q;
      s_d.st        = ST_HARD_ERR;
      s_d.err_code  = ERR_ECC;
      s_d.kat_go    = 1'b0;
      s_d.rx_dv     = 1'b0;
      s_d.tx_dv     = 1'b0;
      s_d.drop_v    = 1'b0;
      s_d.iv_v      = 1'b0;
      s_d.deact     = 1'b0;
      s_d.rdata     = s_q.rdata;
      if (reg_rd_i && (reg_addr_i == ADDR_STATUS)) begin
        s_d.rdata = {27'h000_0000, 5'h04};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.proto_en <= PROTO_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==================== Outputs
  assign reg_rdata_o     = s_q.rdata;
  assign kat_start_o     = s_q.kat_go;
  assign kat_id_o        = s_q.kat_id;
  assign svc_ready_o     = s_q.st == ST_READY;
  assign test_err_o      = s_q.st == ST_TEST_ERR;
  assign hard_err_o      = s_q.st == ST_HARD_ERR;
  assign fatal_irq_o     = s_q.st == ST_HARD_ERR;
  assign err_code_o      = s_q.err_code;
  // Ready low outside service: the processors hold traffic upstream
  assign rx_ready_o      = svc;
  assign tx_ready_o      = svc;
  assign rx_dec_valid_o  = s_q.rx_dv;
  assign rx_crypto_o     = s_q.rx_crypto;
  assign tx_dec_valid_o  = s_q.tx_dv;
  assign tx_crypto_o     = s_q.tx_crypto;
  assign tx_drop_valid_o = s_q.drop_v;
  assign tx_drop_o       = s_q.drop;
  assign iv_ready_o      = svc && iv_ok;
  assign iv_valid_o      = s_q.iv_v;
  assign iv_o            = s_q.iv;
  assign sa_deact_o      = s_q.deact;
  assign psp_expired_o   = psp_exp;

  // ==================== Checks
  chk_tests_autostart: assert property (@(posedge mclk_i) $rose(rst_n) |-> ##[0:1] kat_start_o)
    else $error("self-test did not start after reset");
  chk_fail_error_code: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s_q.st == ST_KAT_WAIT) && kat_done_i && !kat_pass_i && !ecc_any
    |=> test_err_o && (err_code_o == {1'b0, $past(kat_id_o)} + 4'h1))
    else $error("failed test gave no error code");
  chk_no_service_early: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !svc_ready_o |-> !rx_ready_o && !tx_ready_o && !iv_ready_o ##1 !rx_dec_valid_o && !tx_dec_valid_o)
    else $error("traffic accepted outside service");
  chk_error_latched: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (test_err_o || hard_err_o) |=> (test_err_o || hard_err_o) [*3])
    else $error("error state left without reset");
  chk_rx_bypass_status: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_valid_i && rx_ready_o && !rx_ok |=> rx_dec_valid_o && !rx_crypto_o)
    else $error("receive bypass kept crypto status");
  chk_tx_drop_flag: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_ready_o && !tx_valid_i && tx_proc_done_i |=> tx_drop_valid_o && (tx_drop_o == $past(tx_proc_err_i)))
    else $error("drop flag does not follow processing result");
  chk_tx_bypass_drop: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_valid_i && tx_ready_o && !tx_ok |=> tx_dec_valid_o && !tx_crypto_o && tx_drop_valid_o && !tx_drop_o)
    else $error("transmit bypass not cleared for send");
  chk_fault_freeze: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ecc_any |=> fatal_irq_o && !rx_dec_valid_o && !tx_dec_valid_o && !tx_drop_valid_o && !iv_valid_o)
    else $error("memory fault did not freeze outputs");
  chk_store_iv_stall: assert property (@(posedge mclk_i) disable iff (!rst_n)
    iv_req_i && (iv_kind_i == IV_STORE) && (s_q.add_cnt <= s_q.last_add) |-> !iv_ready_o ##1 !iv_valid_o)
    else $error("store IV issued without a fresh counter");
  chk_iv_layout: assert property (@(posedge mclk_i) disable iff (!rst_n)
    iv_req_i && iv_ready_o && (iv_kind_i == IV_PSP) && !psp_exp |=> iv_valid_o && (iv_o[95:64] == $past(iv_salt_i))
    && (iv_o[63:0] == $past(s_q.tmr)))
    else $error("PSP IV layout wrong");
  chk_esp_wrap_deact: assert property (@(posedge mclk_i) disable iff (!rst_n)
    svc && iv_req_i && (iv_kind_i == IV_ESP) && s_q.esp_seen && (esp_seq_i <= s_q.last_esp)
    |=> sa_deact_o && !iv_valid_o)
    else $error("sequence wrap did not deactivate");
  chk_reset_quiet: assert property (@(posedge mclk_i) $rose(rst_n) |-> !svc_ready_o && !test_err_o
    && !hard_err_o && (kat_id_o == 3'h0))
    else $error("reset did not restart the test sequence");
  chk_kat_id_range: assert property (@(posedge mclk_i) disable iff (!rst_n)
    kat_start_o |-> (kat_id_o <= KAT_LAST) ##1 !kat_start_o)
    else $error("test start not a single pulse in range");
  chk_kat_step: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s_q.st == ST_KAT_WAIT) && kat_done_i && kat_pass_i && (kat_id_o != KAT_LAST) && !ecc_any
    |=> ##1 (hard_err_o || (kat_start_o && (kat_id_o == $past(kat_id_o, 2) + 3'h1))))
    else $error("next test not started in order");
  chk_svc_needs_pass: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(svc_ready_o) |-> $past(kat_done_i) && $past(kat_pass_i) && ($past(kat_id_o) == KAT_LAST))
    else $error("service opened without a passed sequence");
  chk_writes_refused: assert property (@(posedge mclk_i) disable iff (!rst_n)
    reg_wr_i && !svc |=> (s_q.proto_en == $past(s_q.proto_en)))
    else $error("control write acted outside service");
  chk_rx_crypto_pick: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_valid_i && rx_ready_o && (rx_meta_i == {PROTO_ESP, 2'b01}) && s_q.proto_en[0]
    |=> rx_dec_valid_o && rx_crypto_o)
    else $error("receive crypto request bypassed");
  chk_tx_crypto_pick: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_valid_i && tx_ready_o && (tx_meta_i == {PROTO_PSP, 2'b11}) && s_q.proto_en[1]
    |=> tx_dec_valid_o && tx_crypto_o && !tx_drop_valid_o)
    else $error("transmit crypto request bypassed");
  chk_ecc_code: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ecc_any |=> (err_code_o == ERR_ECC))
    else $error("memory fault gave no error code");
  chk_store_iv_layout: assert property (@(posedge mclk_i) disable iff (!rst_n)
    iv_req_i && iv_ready_o && (iv_kind_i == IV_STORE)
    |=> iv_valid_o && (iv_o == {$past(iv_salt_i), $past(s_q.add_cnt)}))
    else $error("store IV layout wrong");
  chk_esp_iv_layout: assert property (@(posedge mclk_i) disable iff (!rst_n)
    iv_req_i && iv_ready_o && (iv_kind_i == IV_ESP) && !(s_q.esp_seen && (esp_seq_i <= s_q.last_esp))
    |=> iv_valid_o && (iv_o == {$past(iv_salt_i), $past(esp_seq_i)}))
    else $error("ESP IV layout wrong");
  chk_psp_expired_deact: assert property (@(posedge mclk_i) disable iff (!rst_n)
    iv_req_i && iv_ready_o && (iv_kind_i == IV_PSP) && psp_exp |=> sa_deact_o && !iv_valid_o)
    else $error("expired PSP association still served");

  cov_reach_service: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(svc_ready_o));
  cov_rx_crypto:     cover property (@(posedge mclk_i) disable iff (!rst_n) rx_dec_valid_o && rx_crypto_o);
  cov_tx_dropped:    cover property (@(posedge mclk_i) disable iff (!rst_n) tx_drop_valid_o && tx_drop_o);
  cov_sa_deact:      cover property (@(posedge mclk_i) disable iff (!rst_n) sa_deact_o);
  cov_store_stall:   cover property (@(posedge mclk_i) disable iff (!rst_n) svc && iv_req_i && !iv_ready_o);

endmodule

// ---- test/kat_engine_model.sv ----
// Purpose: Known-answer test engine stand-in
// Assumes: Start pulses arrive one at a time
// Notes:   Fails the test whose index equals fail_id_i
`timescale 1ns/1ps
module kat_engine_model
  import crypto_guard_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       kat_start_i,
  input  wire logic [2:0] kat_id_i,
  input  wire logic [2:0] fail_id_i,
  output logic            kat_done_o,
  output logic            kat_pass_o,
  output logic [2:0]      in_order_o
);
  logic       busy_q;
  logic [1:0] wait_q;
  logic [2:0] id_q;
  // ==================== Engine
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {busy_q, wait_q, id_q, kat_done_o, kat_pass_o, in_order_o} <= '0;
    end else begin
      kat_done_o <= 1'b0;
      // Result line is junk outside done
      kat_pass_o <= ~kat_pass_o;
      if (kat_start_i) begin
        busy_q <= 1'b1;
        wait_q <= 2'h2;
        id_q   <= kat_id_i;
        // Counts starts that come in index order
        if (kat_id_i == in_order_o && in_order_o <= KAT_LAST) begin
          in_order_o <= in_order_o + 3'h1;
        end
      end else if (busy_q) begin
        if (wait_q == 2'h0) begin
          busy_q     <= 1'b0;
          kat_done_o <= 1'b1;
          kat_pass_o <= (id_q != fail_id_i);
        end else begin
          wait_q <= wait_q - 2'h1;
        end
      end
    end
  end
endmodule

// ---- test/crypto_selftest_bypass_iv_guard_tb.sv ----
// Purpose: Self-checking bench of the crypto guard
// Assumes: Assertions live in the design files
// Notes:   Short PSP lifetime keeps the run brief
`timescale 1ns/1ps
module crypto_selftest_bypass_iv_guard_tb;
  import crypto_guard_pkg::*;
  localparam logic [63:0] LIFE = 64'h0000_0000_0000_0032;
  logic mclk_i, reset_n_i, reg_wr_i, reg_rd_i, kat_start_o, kat_done_i, kat_pass_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, iv_salt_i, d;
  logic [2:0] kat_id_o, fail_id, in_order;
  logic svc_ready_o, test_err_o, hard_err_o, fatal_irq_o, rx_valid_i, rx_ready_o;
  logic [3:0] err_code_o, ecc_err_i, rx_meta_i, tx_meta_i;
  logic rx_dec_valid_o, rx_crypto_o, tx_valid_i, tx_ready_o, tx_dec_valid_o, tx_crypto_o;
  logic tx_proc_done_i, tx_proc_err_i, tx_drop_valid_o, tx_drop_o, sa_add_i, esp_sa_open_i;
  logic psp_sa_open_i, iv_req_i, iv_ready_o, iv_valid_o, sa_deact_o, psp_expired_o;
  logic [1:0] iv_kind_i;
  logic [63:0] esp_seq_i, psp_ctr;
  logic [95:0] iv_o;
  int miscompares, compares;
  // ==================== Instances
  crypto_selftest_bypass_iv_guard #(.PSP_LIFE(LIFE), .ECC_N(4)) dut (
    .mclk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .kat_start_o, .kat_id_o, .kat_done_i, .kat_pass_i, .svc_ready_o, .test_err_o,
    .err_code_o, .hard_err_o, .fatal_irq_o, .ecc_err_i, .rx_valid_i, .rx_meta_i,
    .rx_ready_o, .rx_dec_valid_o, .rx_crypto_o, .tx_valid_i, .tx_meta_i, .tx_ready_o,
    .tx_dec_valid_o, .tx_crypto_o, .tx_proc_done_i, .tx_proc_err_i, .tx_drop_valid_o,
    .tx_drop_o, .sa_add_i, .esp_sa_open_i, .psp_sa_open_i, .iv_req_i, .iv_kind_i,
    .iv_salt_i, .esp_seq_i, .iv_ready_o, .iv_valid_o, .iv_o, .sa_deact_o, .psp_expired_o);
  kat_engine_model engine (.mclk_i, .reset_n_i, .kat_start_i(kat_start_o),
    .kat_id_i(kat_id_o), .fail_id_i(fail_id), .kat_done_o(kat_done_i),
    .kat_pass_o(kat_pass_i), .in_order_o(in_order));
  // ==================== Tasks
  task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic restart();
    int n;
    @(posedge mclk_i) reset_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    #1 chk("rx_ready_in_test", rx_ready_o, 0);
    n = 0;
    while (svc_ready_o !== 1'b1 && test_err_o !== 1'b1 && n < 300) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("tests_finished", n < 300, 1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i) reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i) reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i) reg_wr_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask
  // Offers one packet; ready is high throughout service
  task automatic pkt(input logic t, input logic [3:0] m, input logic c);
    @(posedge mclk_i);
    if (t) begin
      tx_valid_i <= 1'b1;
      tx_meta_i  <= m;
    end else begin
      rx_valid_i <= 1'b1;
      rx_meta_i  <= m;
    end
    @(posedge mclk_i) tx_valid_i <= 1'b0;
    rx_valid_i <= 1'b0;
    #1;
    if (t) chk("tx_decision", {tx_dec_valid_o, tx_crypto_o}, {1'b1, c});
    else chk("rx_decision", {rx_dec_valid_o, rx_crypto_o}, {1'b1, c});
  endtask
  task automatic done(input logic e);
    @(posedge mclk_i) tx_proc_done_i <= 1'b1;
    tx_proc_err_i <= e;
    @(posedge mclk_i) tx_proc_done_i <= 1'b0;
    #1 chk("tx_drop", {tx_drop_valid_o, tx_drop_o}, {1'b1, e});
  endtask
  // Holds the request until the taking edge, then drops it
  task automatic iv(input logic [1:0] k, input logic [31:0] s, input logic [63:0] q);
    int n;
    @(posedge mclk_i) iv_req_i <= 1'b1;
    iv_kind_i <= k;
    iv_salt_i <= s;
    esp_seq_i <= q;
    #1 n = 0;
    while (iv_ready_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("iv_served", n < 20, 1);
    @(posedge mclk_i) iv_req_i <= 1'b0;
    #1;
  endtask
  // ==================== Watchdog
  initial begin
    repeat (6000) @(posedge mclk_i);
    miscompares++;
    conclude();
  end
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ==================== Tests
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, ecc_err_i, rx_valid_i} = '0;
    {rx_meta_i, tx_valid_i, tx_meta_i, tx_proc_done_i, tx_proc_err_i, sa_add_i} = '0;
    {esp_sa_open_i, psp_sa_open_i, iv_req_i, iv_kind_i, iv_salt_i, esp_seq_i} = '0;
    fail_id = 3'h2;
    restart();
    chk("kat_fail", {svc_ready_o, test_err_o, err_code_o, rx_ready_o}, 7'b01_0011_0);
    wr(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_CTRL, d);
    chk("ctrl_unacted", d, PROTO_EN_RST);
    rd(ADDR_STATUS, d);
    chk("status_fail", d[7:0], 8'h32);
    fail_id = 3'h7;
    restart();
    chk("kat_pass", {in_order, svc_ready_o}, {3'h5, 1'b1});
    rd(8'h10, d);
    chk("unmapped", d, 0);
    pkt(0, 4'h5, 1);
    pkt(0, 4'h7, 0);
    wr(ADDR_CTRL, 32'h0000_0001);
    pkt(0, 4'h9, 0);
    wr(ADDR_CTRL, 32'h0000_0003);
    pkt(1, 4'h7, 1);
    done(1'b1);
    pkt(1, 4'hB, 1);
    done(1'b0);
    pkt(1, 4'h6, 0);
    chk("tx_bypass_drop", {tx_drop_valid_o, tx_drop_o}, 2'b10);
    // Store counter starts equal to the last IV, so this must stall
    @(posedge mclk_i) iv_req_i <= 1'b1;
    iv_kind_i <= IV_STORE;
    repeat (3) @(posedge mclk_i);
    #1 chk("store_stall", iv_ready_o, 0);
    @(posedge mclk_i) iv_req_i <= 1'b0;
    sa_add_i <= 1'b1;
    @(posedge mclk_i) sa_add_i <= 1'b0;
    iv(IV_STORE, 32'hA5A5_0001, 0);
    chk("store_iv", {iv_valid_o, iv_o}, {1'b1, 32'hA5A5_0001, 64'h1});
    rd(ADDR_ADD_LO, d);
    chk("add_lo", d, 32'h0000_0001);
    @(posedge mclk_i) esp_sa_open_i <= 1'b1;
    @(posedge mclk_i) esp_sa_open_i <= 0;
    iv(IV_ESP, 32'h1234_5678, 64'h5);
    chk("esp_iv", {iv_valid_o, sa_deact_o, iv_o}, {2'b10, 32'h1234_5678, 64'h5});
    iv(IV_ESP, 32'h1234_5678, 64'h5);
    chk("esp_wrap", {iv_valid_o, sa_deact_o}, 2'b01);
    iv(2'h3, 32'h0, 0);
    chk("bad_kind", {iv_valid_o, sa_deact_o}, 2'b01);
    @(posedge mclk_i) psp_sa_open_i <= 1'b1;
    @(posedge mclk_i) psp_sa_open_i <= 0;
    iv(IV_PSP, 32'h0BAD_F00D, 0);
    chk("psp_iv", {iv_valid_o, sa_deact_o, iv_o[95:64]}, {2'b10, 32'h0BAD_F00D});
    psp_ctr = iv_o[63:0];
    // Back-to-back request is taken two timer ticks later
    iv(IV_PSP, 32'h0BAD_F00D, 0);
    chk("psp_iv_next", {iv_valid_o, iv_o[63:0]}, {1'b1, psp_ctr + 64'h2});
    repeat (60) @(posedge mclk_i);
    #1 chk("psp_life", psp_expired_o, 1);
    iv(IV_PSP, 32'h0BAD_F00D, 0);
    chk("psp_dead", {iv_valid_o, sa_deact_o}, 2'b01);
    @(posedge mclk_i) ecc_err_i <= 4'h4;
    @(posedge mclk_i) ecc_err_i <= 4'h0;
    #1 chk("ecc_fault", {hard_err_o, fatal_irq_o, rx_ready_o}, 3'b110);
    repeat (10) @(posedge mclk_i);
    #1 chk("ecc_latch", {hard_err_o, svc_ready_o, tx_ready_o, err_code_o}, {3'b100, ERR_ECC});
    rd(ADDR_STATUS, d);
    chk("status_hard", d, 32'h0000_0004);
    conclude();
  end
endmodule
